/* hdl/hpmp_device.sv */
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module hpmp_device
  import hpmp_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Host pins
  hpmp_if.dev             port,
  // Line side
  input  wire logic [7:0] line_status,
  input  wire logic       return_zero_mode,
  input  wire logic       data_recovery_only,
  input  wire logic       rx_pos_raw,
  input  wire logic       rx_neg_raw,
  // Static controls to the line side, and the receive data taken from it
  output logic      [2:0] pulse_shape_code,
  output logic            line_is_e1,
  output logic            ja_in_tx,
  output logic            ja_in_rx,
  output logic            zero_sub_enable,
  output logic            timing_clock_enable,
  output logic            rx_change_on_rising,
  output logic      [7:0] tx_driver_hiz,
  output logic            rx_positive_data,
  output logic            rx_negative_data
);
  logic [7:0]      regs_r [REG_COUNT];
  logic [7:0]      changes;
  hpmp_pstate_type pstate_r;
  logic [2:0]      wait_cnt_r;
  logic            is_read_r;
  logic [4:0]      cur_addr_r;
  logic [4:0]      addr_latch_r;
  logic [7:0]      d_out_r;
  logic            sclk_q_r;
  logic [4:0]      ser_cnt_r;
  logic [7:0]      ser_sh_r;
  logic [7:0]      rd_sh_r;
  logic            ser_read_r;

  wire is_hw  = (port.mode_sel == hpmp_mode_hw);
  wire is_par = (port.mode_sel == hpmp_mode_par);
  wire is_ser = (port.mode_sel == hpmp_mode_ser);
  wire sep    = port.host_bus_style;

  wire par_wr  = sep ? !port.pin_a : (!port.pin_a && !port.pin_b);
  wire par_rd  = sep ? !port.pin_b : (!port.pin_a && port.pin_b);
  wire par_req = is_par && !port.cs_pin && (par_wr || par_rd);

  wire       alat     = sep ? port.pin_c : !port.pin_c;
  wire [4:0] acc_addr = port.mux_sel ? addr_latch_r : port.addr;

  // Commit point of a parallel access
  wire       p_idle   = (pstate_r == hpmp_p_idle);
  wire       p_commit = (p_idle && par_req && return_zero_mode) ||
                        (pstate_r == hpmp_p_wait && wait_cnt_r == 3'h0);
  wire [4:0] p_addr   = p_idle ? acc_addr : cur_addr_r;
  wire       p_read   = p_idle ? par_rd : is_read_r;

  // Serial edges and the byte just completed
  wire       ser_on   = is_ser && !port.cs_pin;
  wire       rise     = ser_on && port.pin_c && !sclk_q_r;
  wire       fall     = ser_on && !port.pin_c && sclk_q_r;
  wire [7:0] ser_byte = {port.pin_a, ser_sh_r[7:1]};
  wire       ser_cmd  = rise && (ser_cnt_r == SER_CMD_BITS - 5'h01);
  wire       ser_wr   = rise && (ser_cnt_r == SER_TOTAL - 5'h01) && !ser_read_r;

  // Register write port shared by both host styles
  wire       wr_en   = (p_commit && !p_read) || ser_wr;
  wire [4:0] wr_addr = is_ser ? cur_addr_r : p_addr;
  wire [7:0] wr_data = is_ser ? ser_byte : port.data_bus;

  // Read value and status clear
  wire [4:0] rd_addr = is_ser ? ser_byte[5:1] : p_addr;
  wire [7:0] rd_val  = (rd_addr == REG_STATUS) ? changes : regs_r[rd_addr];
  wire       rd_hit  = (p_commit && p_read) || (ser_cmd && ser_byte[0]);
  wire       clr     = rd_hit && (rd_addr == REG_STATUS);

  hpmp_status_bank u_bank (
    .pclk      (pclk),
    .presetn   (presetn),
    .status_in (line_status),
    .enable    (regs_r[REG_IRQ_EN]),
    .clear     (clr),
    .changes_r (changes),
    .int_oe_n  (port.int_oe_n)
  );

  // Register array; status itself is not writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (wr_en && wr_addr != REG_STATUS) begin
      regs_r[wr_addr] <= wr_data;
    end
  end

  // Address latch in multiplexed operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_latch_r <= 5'h00;
    end else if (is_par && port.mux_sel && alat) begin
      addr_latch_r <= port.data_bus[4:0];
    end
  end

  // Parallel access sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_r   <= hpmp_p_idle;
      wait_cnt_r <= 3'h0;
      is_read_r  <= 1'b0;
    end else begin
      unique case (pstate_r)
        hpmp_p_idle: begin
          if (par_req) begin
            is_read_r  <= par_rd;
            wait_cnt_r <= WAIT_CYCLES;
            // skip wait states in return-to-zero mode
            pstate_r   <= return_zero_mode ? hpmp_p_done : hpmp_p_wait;
          end
        end
        hpmp_p_wait: begin
          if (wait_cnt_r == 3'h0) begin
            pstate_r <= hpmp_p_done;
          end else begin
            wait_cnt_r <= wait_cnt_r - 3'h1;
          end
        end
        hpmp_p_done: begin
          // end of bus cycle returns to idle
          if (!par_req) begin
            pstate_r <= hpmp_p_idle;
          end
        end
        default: begin
          pstate_r <= hpmp_p_idle;
        end
      endcase
    end
  end

  // Access address held for the whole cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_addr_r <= 5'h00;
    end else if (p_idle && par_req) begin
      cur_addr_r <= acc_addr;
    end else if (ser_cmd) begin
      cur_addr_r <= ser_byte[5:1];
    end
  end

  // Parallel read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_out_r <= 8'h00;
    end else if (p_commit && p_read) begin
      d_out_r <= rd_val;
    end
  end

  // Serial clock history; pins are synchronous so one stage is enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= port.pin_c;
    end
  end

  // Serial input shifting, LSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_cnt_r <= 5'h00;
      ser_sh_r  <= 8'h00;
    end else if (!ser_on) begin
      ser_cnt_r <= 5'h00;
    end else if (rise && ser_cnt_r != SER_TOTAL) begin
      ser_sh_r  <= ser_byte;
      ser_cnt_r <= ser_cnt_r + 5'h01;
    end
  end

  // Serial read data; launch edge follows the edge select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_read_r <= 1'b0;
      rd_sh_r    <= 8'h00;
    end else if (!ser_on) begin
      ser_read_r <= 1'b0;
    end else if (ser_cmd) begin
      ser_read_r <= ser_byte[0];
      rd_sh_r    <= rd_val;
    // launch on the edge opposite the valid edge
    end else if (port.sample_edge_select ? (fall && ser_cnt_r >= SER_CMD_BITS + 5'h01)
                                         : (rise && ser_cnt_r >= SER_CMD_BITS)) begin
      rd_sh_r <= {1'b0, rd_sh_r[7:1]};
    end
  end

  // Handshake and serial output share one pin
  always_comb begin
    port.hs_out  = 1'b1;
    port.hs_oe_n = 1'b1;
    if (is_ser) begin
      port.hs_out  = rd_sh_r[0];
      port.hs_oe_n = !(ser_on && ser_read_r);
    end else if (is_par && !p_idle) begin
      port.hs_oe_n = 1'b0;
      if (pstate_r == hpmp_p_wait) begin
        port.hs_out = !sep && !is_read_r;
      end else begin
        port.hs_out = sep || is_read_r;
      end
    end
  end

  // Parallel data drive during a finished read
  assign port.data_d      = d_out_r;
  assign port.data_d_oe_n = !(is_par && pstate_r == hpmp_p_done && is_read_r);

  // Hardware-mode static controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_shape_code    <= 3'h0;
      line_is_e1          <= 1'b0;
      ja_in_tx            <= 1'b0;
      ja_in_rx            <= 1'b0;
      zero_sub_enable     <= 1'b0;
      timing_clock_enable <= 1'b0;
    end else begin
      pulse_shape_code    <= is_hw ? {port.pin_c, port.pin_b, port.pin_a} : 3'h0;
      line_is_e1          <= is_hw && ({port.pin_c, port.pin_b, port.pin_a} <= LEN_E1_MAX);
      ja_in_tx            <= is_hw && !port.cs_open && !port.cs_pin;
      ja_in_rx            <= is_hw && !port.cs_open && port.cs_pin;
      // zero substitution when coding input low
      zero_sub_enable     <= is_hw && !port.host_bus_style;
      // timing clock recovery in hardware mode
      timing_clock_enable <= is_hw && port.mux_sel;
    end
  end

  // Transmit gating and receive data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_driver_hiz       <= 8'hff;
      rx_change_on_rising <= 1'b0;
      rx_positive_data    <= 1'b0;
      rx_negative_data    <= 1'b0;
    end else begin
      // global gate plus per-driver disables in host mode
      tx_driver_hiz       <= {8{!port.tx_driver_gate_n}} |
                             (is_hw ? 8'h00 : regs_r[REG_OUT_DIS]);
      // falling-edge valid when edge select high
      rx_change_on_rising <= port.sample_edge_select;
      rx_positive_data    <= rx_pos_raw ^ (data_recovery_only && !port.sample_edge_select);
      rx_negative_data    <= rx_neg_raw ^ (data_recovery_only && !port.sample_edge_select);
    end
  end
endmodule : hpmp_device

/* inc/hpmp_pkg.sv */
// Summary of operation
// - Interrupt low on enabled status change
// - Status register read releases interrupt
// - Each change maskable by enable register
// - Separate strobes: ready low, then high
// - Data strobe read: acknowledge high, data valid
// - Data strobe write: acknowledge low when accepted
// - Handshake pin floats after each cycle
// - Return-to-zero mode: no wait states
// - Serial write never drives serial output
// - Host uses strobe style selected
// - Host latches address in multiplexed mode
// - Host drives serial clock both directions
// - Host asserts chip select for access
// - Bus-style input picks strobe style
// - Mux input: multiplex or timing clock
// - Line-length inputs pick shape, rate
// - Jitter input places or disables attenuator
// - Coding input low enables zero substitution
// - Gate input floats all drivers
// - Edge select sets launch edges
// - Edge select sets data-only polarity
// - Mode input picks hardware, parallel, serial
package hpmp_pkg;
  // Operating mode pin state
  typedef enum logic [1:0] {
    hpmp_mode_hw  = 2'b00,
    hpmp_mode_par = 2'b01,
    hpmp_mode_ser = 2'b10
  } hpmp_mode_type;

  // Device parallel access states
  typedef enum logic [1:0] {
    hpmp_p_idle = 2'b00,
    hpmp_p_wait = 2'b01,
    hpmp_p_done = 2'b10
  } hpmp_pstate_type;

  // Controller sequencing states
  typedef enum logic [2:0] {
    hpmp_h_idle  = 3'b000,
    hpmp_h_alat  = 3'b001,
    hpmp_h_setup = 3'b010,
    hpmp_h_strb  = 3'b011,
    hpmp_h_rel   = 3'b100,
    hpmp_h_ser   = 3'b101
  } hpmp_hstate_type;

  // Device register map (5-bit index)
  localparam logic [4:0] REG_STATUS  = 5'h00;
  localparam logic [4:0] REG_IRQ_EN  = 5'h01;
  localparam logic [4:0] REG_OUT_DIS = 5'h12;
  localparam int         REG_COUNT   = 32;
  localparam logic [7:0] REG_RESET   = 8'h00;

  // Timing counts in pclk cycles; serial command and frame lengths in bits
  localparam logic [2:0] WAIT_CYCLES = 3'h2;
  localparam logic [3:0] SCLK_HALF   = 4'h2;
  localparam logic [4:0] SER_CMD_BITS = 5'h08;
  localparam logic [4:0] SER_TOTAL    = 5'h10;

  // Line-length codes at or below this select 2.048 Mbps
  localparam logic [2:0] LEN_E1_MAX = 3'h1;
  localparam logic [7:0] BUS_PULL   = 8'hff;

  // Controller APB map
  localparam logic [7:0] APB_CTRL   = 8'h00;
  localparam logic [7:0] APB_ADDR   = 8'h04;
  localparam logic [7:0] APB_WDATA  = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam logic [7:0] APB_CFG    = 8'h10;
  localparam logic [31:0] CFG_RESET = 32'h0000_0020;
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_READ  = 1;
  localparam int CFG_MODE   = 0;
  localparam int CFG_STYLE  = 2;
  localparam int CFG_MUX    = 3;
  localparam int CFG_EDGE   = 4;
  localparam int CFG_TXGATE = 5;
  localparam int CFG_LEN    = 6;
  localparam int CFG_JPIN   = 9;
  localparam int CFG_JOPEN  = 10;
endpackage : hpmp_pkg

/* inc/hpmp_if.sv */
`timescale 1ns/1ps
interface hpmp_if;
  import hpmp_pkg::*;
  // Straps and static controls
  logic [1:0] mode_sel;
  logic       host_bus_style;
  logic       mux_sel;
  logic       tx_driver_gate_n;
  logic       sample_edge_select;
  // Chip select / jitter pin, open flag models an unconnected pin
  logic       cs_pin;
  logic       cs_open;
  // Shared strobe pins
  logic       pin_a;
  logic       pin_b;
  logic       pin_c;
  logic [4:0] addr;
  // Data bus, both drivers
  logic [7:0] data_h;
  logic       data_h_oe_n;
  logic [7:0] data_d;
  logic       data_d_oe_n;
  logic [7:0] data_bus;
  // Handshake / serial output
  logic       hs_out;
  logic       hs_oe_n;
  logic       hs_level;
  // Open-drain interrupt
  logic       int_oe_n;
  logic       int_n;

  // Wire levels with pull-ups
  assign data_bus = !data_d_oe_n ? data_d : (!data_h_oe_n ? data_h : BUS_PULL);
  assign hs_level = hs_oe_n ? 1'b1 : hs_out;
  assign int_n    = int_oe_n;

  modport dev (
    input  mode_sel, host_bus_style, mux_sel, tx_driver_gate_n, sample_edge_select,
    input  cs_pin, cs_open, pin_a, pin_b, pin_c, addr, data_bus,
    output data_d, data_d_oe_n, hs_out, hs_oe_n, int_oe_n
  );
  modport host (
    output mode_sel, host_bus_style, mux_sel, tx_driver_gate_n, sample_edge_select,
    output cs_pin, cs_open, pin_a, pin_b, pin_c, addr, data_h, data_h_oe_n,
    input  data_bus, hs_level, hs_oe_n, int_n
  );
endinterface : hpmp_if

/* hdl/hpmp_status_bank.sv */
`timescale 1ns/1ps
module hpmp_status_bank
  import hpmp_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Status and controls
  input  wire logic [7:0] status_in,
  input  wire logic [7:0] enable,
  input  wire logic       clear,
  // Results
  output logic      [7:0] changes_r,
  output logic            int_oe_n
);
  logic [7:0] prev_r;

  // Previous status for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 8'h00;
    end else begin
      prev_r <= status_in;
    end
  end

  // Sticky change bits; a new change beats the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      changes_r <= 8'h00;
    end else begin
      changes_r <= (changes_r & ~{8{clear}}) | (status_in ^ prev_r);
    end
  end

  assign int_oe_n = ~|(changes_r & enable);
endmodule : hpmp_status_bank

/* hdl/hpmp_host.sv */
`timescale 1ns/1ps
module hpmp_host
  import hpmp_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device pins
  hpmp_if.host             port
);
  logic [31:0]     cfg_r;
  logic [4:0]      addr_r;
  logic [7:0]      wdata_r;
  logic [7:0]      rdata_r;
  logic            read_r;
  hpmp_hstate_type st_r;
  logic [15:0]     frame_r;
  logic [4:0]      bit_r;
  logic [3:0]      hc_r;
  logic            sclk_r;

  wire       sep     = cfg_r[CFG_STYLE];
  wire       edge_hi = cfg_r[CFG_EDGE];
  wire [1:0] mode    = cfg_r[CFG_MODE +: 2];
  wire       acc     = psel && penable;
  wire       start   = acc && pwrite && paddr == APB_CTRL && pwdata[CTRL_START] &&
                       st_r == hpmp_h_idle;
  // Expected handshake level: ready high, or acknowledge by direction
  wire       hs_ok   = !port.hs_oe_n && (port.hs_level == (sep || read_r));

  // APB: zero wait states, error on unmapped offsets
  assign pready  = 1'b1;
  assign pslverr = acc && !(paddr == APB_CTRL || paddr == APB_ADDR ||
                   paddr == APB_WDATA || paddr == APB_STATUS || paddr == APB_CFG);
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      APB_ADDR:   prdata = {27'h0, addr_r};
      APB_WDATA:  prdata = {24'h0, wdata_r};
      APB_STATUS: prdata = {16'h0, rdata_r, 6'h0, !port.int_n, st_r != hpmp_h_idle};
      APB_CFG:    prdata = cfg_r;
      default:    prdata = 32'h0000_0000;
    endcase
  end

  // Configuration and request registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r   <= CFG_RESET;
      addr_r  <= 5'h00;
      wdata_r <= 8'h00;
      read_r  <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == APB_CFG) cfg_r <= pwdata;
      if (paddr == APB_ADDR) addr_r <= pwdata[4:0];
      if (paddr == APB_WDATA) wdata_r <= pwdata[7:0];
      if (start) read_r <= pwdata[CTRL_READ];
    end
  end

  // Access sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= hpmp_h_idle;
      rdata_r <= 8'h00;
      frame_r <= 16'h0000;
      bit_r   <= 5'h00;
      hc_r    <= 4'h0;
      sclk_r  <= 1'b0;
    end else begin
      unique case (st_r)
        hpmp_h_idle: begin
          if (start && mode == hpmp_mode_ser) begin
            frame_r <= {wdata_r, 2'b00, addr_r, pwdata[CTRL_READ]};
            bit_r   <= 5'h00;
            hc_r    <= SCLK_HALF - 4'h1;
            sclk_r  <= 1'b0;
            st_r    <= hpmp_h_ser;
          end else if (start && mode == hpmp_mode_par) begin
            st_r <= cfg_r[CFG_MUX] ? hpmp_h_alat : hpmp_h_setup;
          end
        end
        hpmp_h_alat:  st_r <= hpmp_h_setup;
        hpmp_h_setup: st_r <= hpmp_h_strb;
        hpmp_h_strb: begin
          if (hs_ok) begin
            if (read_r) rdata_r <= port.data_bus;
            st_r <= hpmp_h_rel;
          end
        end
        hpmp_h_rel: begin
          if (port.hs_oe_n) st_r <= hpmp_h_idle;
        end
        hpmp_h_ser: begin
          if (hc_r != 4'h0) begin
            hc_r <= hc_r - 4'h1;
          end else begin
            hc_r   <= SCLK_HALF - 4'h1;
            sclk_r <= !sclk_r;
            if (!sclk_r) begin
              bit_r <= bit_r + 5'h01;
              if (read_r && edge_hi && bit_r >= SER_CMD_BITS)
                rdata_r <= {port.hs_level, rdata_r[7:1]};
            end else begin
              frame_r <= {1'b0, frame_r[15:1]};
              if (read_r && !edge_hi && bit_r >= SER_CMD_BITS && bit_r < SER_TOTAL)
                rdata_r <= {port.hs_level, rdata_r[7:1]};
              if (bit_r == SER_TOTAL) st_r <= hpmp_h_rel;
            end
          end
        end
        default: st_r <= hpmp_h_idle;
      endcase
    end
  end

  wire strb = (st_r == hpmp_h_strb);
  wire alat = (st_r == hpmp_h_alat);
  wire hw   = (mode == hpmp_mode_hw);
  wire ser  = (mode == hpmp_mode_ser);

  // Static straps
  assign port.mode_sel           = mode;
  assign port.host_bus_style     = sep;
  assign port.mux_sel            = cfg_r[CFG_MUX];
  assign port.tx_driver_gate_n   = cfg_r[CFG_TXGATE];
  assign port.sample_edge_select = edge_hi;
  assign port.cs_open            = hw && cfg_r[CFG_JOPEN];
  assign port.addr               = addr_r;

  // chip select during setup, strobe and the serial frame; high during address latch and release
  assign port.cs_pin = hw ? cfg_r[CFG_JPIN] :
                       !(st_r == hpmp_h_setup || strb || st_r == hpmp_h_ser);
  assign port.pin_a  = hw ? cfg_r[CFG_LEN] : ser ? frame_r[0] :
                       sep ? !(strb && !read_r) : !strb;
  assign port.pin_b  = hw ? cfg_r[CFG_LEN + 1] : ser ? 1'b1 :
                       sep ? !(strb && read_r) : read_r;
  assign port.pin_c  = hw ? cfg_r[CFG_LEN + 2] : ser ? sclk_r : (sep ? alat : !alat);

  // Address phase, then write data
  assign port.data_h      = alat ? {3'h0, addr_r} : wdata_r;
  assign port.data_h_oe_n = !(alat || ((st_r == hpmp_h_setup || strb) && !read_r));
endmodule : hpmp_host

/* tb/hpmp_properties.sv */
`timescale 1ns/1ps
module hpmp_properties
  import hpmp_pkg::*;
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Straps and strobes
  input wire logic [1:0] mode_sel,
  input wire logic       host_bus_style,
  input wire logic       cs_pin,
  input wire logic       pin_a,
  input wire logic       pin_b,
  input wire logic       pin_c,
  // Device drivers
  input wire logic       data_d_oe_n,
  input wire logic       hs_out,
  input wire logic       hs_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] rise_r;
  logic       rd_r;
  logic       par;
  logic       ser;
  // Mode decode
  assign par = (mode_sel == hpmp_mode_par);
  assign ser = (mode_sel == hpmp_mode_ser);
  // Serial clock rises per frame; read bit is the first one shifted in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_r <= 5'h00;
      rd_r   <= 1'b0;
    end else if (cs_pin) begin
      rise_r <= 5'h00;
      rd_r   <= 1'b0;
    end else if ($rose(pin_c)) begin
      rise_r <= rise_r + 5'h01;
      if (rise_r == 5'h00) rd_r <= pin_a;
    end
  end
  chk_hs_float_idle: assert property (cs_pin && $past(cs_pin) |-> hs_oe_n)
    else $error("handshake driven while deselected");
  chk_data_float_idle: assert property (cs_pin && $past(cs_pin) |-> data_d_oe_n)
    else $error("data bus driven while deselected");
  chk_sep_ready_low: assert property (par && host_bus_style && !hs_oe_n && $past(hs_oe_n) == 1'b0
    && $rose(hs_out) |-> $past(hs_oe_n, 3) == 1'b0 && $past(hs_out, 3) == 1'b0)
    else $error("ready rose without wait cycles");
  chk_ds_read_data: assert property (par && !host_bus_style && pin_b && !cs_pin && !pin_a
    && !hs_oe_n && hs_out |-> !data_d_oe_n)
    else $error("read acknowledge without data");
  chk_ds_write_ack: assert property (par && !host_bus_style && !pin_b && !hs_oe_n
    && $past(hs_oe_n) == 1'b0 && $fell(hs_out) |-> $past(hs_out, 3) == 1'b1)
    else $error("write acknowledge too early");
  chk_ser_write_float: assert property (ser && !cs_pin && (!rd_r || rise_r < 5'h08) |-> hs_oe_n)
    else $error("serial output driven outside read data");
  chk_strobe_style: assert property ($fell(hs_oe_n) && par |-> !$past(cs_pin)
    && (!$past(pin_a) || (host_bus_style && !$past(pin_b))))
    else $error("handshake without a strobe of the chosen style");
  chk_hw_mode_quiet: assert property (mode_sel == hpmp_mode_hw
    && $past(mode_sel) == hpmp_mode_hw |-> hs_oe_n && data_d_oe_n)
    else $error("host pins driven in hardware mode");
endmodule : hpmp_properties

/* tb/test_host_port_and_mode_pins.sv */
`timescale 1ns/1ps
module test_host_port_and_mode_pins;
  import hpmp_pkg::*;
  // Stimulus
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  line_status = 8'h00;
  logic        ret0 = 1'b0;
  logic        drec = 1'b1;
  // Observed values
  logic [31:0] prdata, rd_v;
  logic        pready, pslverr, err_v, e1, jtx, jrx, zsub, tclk, edge_q, rxp_q, rxn_q;
  logic [2:0]  shape, b;
  logic [7:0]  hiz;
  int          n_fail = 0, checked = 0, cyc = 0, wait_seen = 0;
  // Rows: configuration beside the byte that must read back
  logic [31:0] cfg_t [6] = '{32'h25, 32'h2d, 32'h21, 32'h29, 32'h32, 32'h22};
  logic [7:0]  dat_t [6] = '{8'ha5, 8'h5a, 8'h01, 8'h80, 8'hc3, 8'h3c};
  hpmp_if port_if ();
  always #5 pclk = ~pclk;
  hpmp_host hpmp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port(port_if.host));
  hpmp_device hpmp_device_inst (.pclk(pclk), .presetn(presetn), .port(port_if.dev),
    .line_status(line_status), .return_zero_mode(ret0), .data_recovery_only(drec),
    .rx_pos_raw(1'b1), .rx_neg_raw(1'b0), .pulse_shape_code(shape), .line_is_e1(e1),
    .ja_in_tx(jtx), .ja_in_rx(jrx), .zero_sub_enable(zsub), .timing_clock_enable(tclk),
    .rx_change_on_rising(edge_q), .tx_driver_hiz(hiz), .rx_positive_data(rxp_q),
    .rx_negative_data(rxn_q));
  hpmp_properties hpmp_properties_inst (.pclk(pclk), .presetn(presetn),
    .mode_sel(port_if.mode_sel), .host_bus_style(port_if.host_bus_style),
    .cs_pin(port_if.cs_pin), .pin_a(port_if.pin_a), .pin_b(port_if.pin_b),
    .pin_c(port_if.pin_c), .data_d_oe_n(port_if.data_d_oe_n), .hs_out(port_if.hs_out),
    .hs_oe_n(port_if.hs_oe_n));
  // Wait levels seen in return-to-zero mode; hang ceiling
  always @(posedge pclk) begin
    cyc++;
    if (ret0 && !port_if.hs_oe_n && port_if.hs_level === 1'b0) wait_seen++;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One APB transfer; waits for pready, never assumes its timing
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Device register access through the controller, polled until idle
  task automatic dev(input logic rd, input logic [4:0] a, input logic [7:0] d);
    int n;
    apb(APB_ADDR, 1'b1, {27'h0, a});
    apb(APB_WDATA, 1'b1, {24'h0, d});
    apb(APB_CTRL, 1'b1, {30'h0, rd, 1'b1});
    n = 0;
    do begin
      apb(APB_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd_v[0] !== 1'b0 && n < 100);
    chk(rd_v[0], 1'b0, "busy");
  endtask : dev
  task automatic complete_run();
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    chk(hiz, 8'hff, "hiz in reset");
    chk(port_if.hs_level, 1'b1, "hs in reset");
    chk(port_if.int_n, 1'b1, "int in reset");
    presetn <= 1'b1;
    apb(APB_CFG, 1'b0, 32'h0);
    chk(rd_v, CFG_RESET, "cfg reset");
    chk(pready, 1'b1, "ready");
    // Unmapped offset is refused
    apb(8'h14, 1'b0, 32'h0);
    chk(err_v, 1'b1, "unmapped err");
    chk(rd_v, 32'h0, "unmapped data");
    // Every bus style and serial edge; a neighbour write catches address faults
    for (int i = 0; i < 6; i++) begin
      apb(APB_CFG, 1'b1, cfg_t[i]);
      dev(1'b0, REG_OUT_DIS, dat_t[i]);
      dev(1'b0, 5'h13, ~dat_t[i]);
      dev(1'b1, REG_OUT_DIS, 8'h00);
      chk(rd_v[15:8], dat_t[i], "readback");
      chk(hiz, dat_t[i], "hiz host");
    end
    // Hardware mode straps, all line-length codes
    for (int i = 0; i < 8; i++) begin
      b = i[2:0];
      apb(APB_CFG, 1'b1, {21'h0, b[1] & b[2], b[0], b, 1'b1, b[2], b[1], b[0], 2'b00});
      repeat (3) @(posedge pclk);
      chk(shape, b, "shape");
      chk(e1, b <= LEN_E1_MAX, "rate");
      chk(zsub, !b[0], "coding");
      chk(tclk, b[1], "timing clock");
      chk(jtx, !(b[1] & b[2]) && !b[0], "ja tx");
      chk(jrx, !(b[1] & b[2]) && b[0], "ja rx");
      chk(edge_q, b[2], "edge");
      chk({rxp_q, rxn_q}, {b[2], !b[2]}, "rx polarity");
      chk(hiz, 8'h00, "hiz hw");
    end
    // Clock/data recovery: raw levels pass unchanged
    drec <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({rxp_q, rxn_q}, 2'b10, "rx plain");
    apb(APB_CFG, 1'b1, 32'h01);
    repeat (3) @(posedge pclk);
    chk(hiz, 8'hff, "gate low");
    // Interrupt: masked change, enabled change, release by status read
    apb(APB_CFG, 1'b1, 32'h25);
    dev(1'b0, REG_IRQ_EN, 8'h01);
    line_status <= 8'h02;
    repeat (4) @(posedge pclk);
    chk(port_if.int_n, 1'b1, "masked");
    line_status <= 8'h03;
    repeat (4) @(posedge pclk);
    chk(port_if.int_n, 1'b0, "int low");
    apb(APB_STATUS, 1'b0, 32'h0);
    chk(rd_v[1], 1'b1, "int flag");
    dev(1'b1, REG_STATUS, 8'h00);
    chk(rd_v[15:8], 8'h03, "status bits");
    repeat (3) @(posedge pclk);
    chk(port_if.int_n, 1'b1, "int released");
    // Return-to-zero: no wait level on the handshake
    ret0 <= 1'b1;
    dev(1'b0, 5'h05, 8'h66);
    dev(1'b1, 5'h05, 8'h00);
    chk(rd_v[15:8], 8'h66, "rtz data");
    chk(wait_seen, 32'h0, "rtz wait");
    complete_run();
  end
endmodule : test_host_port_and_mode_pins
